// *** shared/pmic_flags_pkg.sv ***
// Shared constants for the power controller status and flag registers
`default_nettype none
package pmic_flags_pkg;

   // ==========================================================
   // Serial bus
   localparam logic [6:0] DEVICE_ADDR      = 7'h24;

   // ==========================================================
   // Register subaddresses
   localparam logic [7:0] PMIC_STATUS_ADDR = 8'h05;
   localparam logic [7:0] POWER_CTRL_ADDR  = 8'h06;
   localparam logic [7:0] RESUME_FLAG_ADDR = 8'h07;

   // ==========================================================
   // Reset values and the read value of unmapped subaddresses
   localparam logic [7:0] POWER_CTRL_RST   = 8'h00;
   localparam logic [7:0] RESUME_FLAG_RST  = 8'h00;
   localparam logic [1:0] COIN_LEVEL_RST   = 2'h0;
   localparam logic [7:0] READ_ZERO        = 8'h00;

   // ==========================================================
   // Field positions
   localparam int SEAL_BIT      = 7;
   localparam int NVM_BIT       = 6;
   localparam int ADAPTER_BIT   = 5;
   localparam int BUTTON_BIT    = 4;
   localparam int PSTATE_LSB    = 2;
   localparam int COIN_LSB      = 0;
   localparam int PF_SHDN_BIT   = 1;
   localparam int COIN_ACQ_BIT  = 0;

   // ==========================================================
   // Power state codes
   localparam logic [1:0] PSTATE_TRANSITION = 2'h0;
   localparam logic [1:0] PSTATE_WAIT_EN    = 2'h1;
   localparam logic [1:0] PSTATE_ACTIVE     = 2'h2;
   localparam logic [1:0] PSTATE_SUSPEND    = 2'h3;

   // ==========================================================
   // Serial slave states
   typedef enum logic [8:0] {
      ST_IDLE      = 9'b000000001,
      ST_ADDR      = 9'b000000010,
      ST_ADDR_ACK  = 9'b000000100,
      ST_SUB       = 9'b000001000,
      ST_SUB_ACK   = 9'b000010000,
      ST_WDATA     = 9'b000100000,
      ST_WDATA_ACK = 9'b001000000,
      ST_RDATA     = 9'b010000000,
      ST_MACK      = 9'b100000000
   } bus_state_e;

endpackage
`default_nettype wire

// *** hdl/level_sync.sv ***
// Two-stage synchroniser for slow asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // ==========================================================
   // First stage feeds only the second
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule // level_sync
`default_nettype wire

// *** hdl/pmic_status_control_flags.sv ***
// Status, control and resume-flag registers behind the serial register bus
`timescale 1ns/1ps
`default_nettype none
module pmic_status_control_flags
   import pmic_flags_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   // Serial register bus
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   // Nonvolatile state
   input  wire logic       factory_seal_broken_i,
   input  wire logic       nvm_changed_i,
   // Pins
   input  wire logic       adapter_detect_pin_n_i,
   input  wire logic       push_button_pin_n_i,
   input  wire logic       power_fail_out_n_i,
   // Power sequencer
   input  wire logic [1:0] power_state_i,
   input  wire logic       power_up_i,
   input  wire logic       from_suspend_i,
   input  wire logic [7:0] suspend_enables_i,
   output logic            shutdown_all_o,
   // Coin-cell converter
   input  wire logic       coin_cell_done_i,
   input  wire logic [1:0] coin_cell_result_i,
   output logic            coin_cell_acquire_o
);
   // ==========================================================
   // Declarations
   bus_state_e state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic       rw_q, rw_d;
   logic       drv_q, drv_d;
   logic       oe_q, oe_d;
   logic       mack_q, mack_d;
   logic       scl_q, sda_q;
   logic       rise, fall, start, stop;
   logic       load_tx;
   logic       wr_en;
   logic [7:0] rd_data;
   logic       seal_q, seal_d, nvm_q, nvm_d;
   logic       pf_shdn_q, pf_shdn_d;
   logic       acq_q, acq_d;
   logic       acq_pulse_q, acq_pulse_d;
   logic       shdn_q, shdn_d;
   logic [1:0] coin_q, coin_d;
   logic [7:0] flags_q, flags_d;
   logic       adapter_level, button_level;

   // ==========================================================
   // Pin synchronisers
   level_sync #(.WIDTH(1)) u_adapter_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i (~adapter_detect_pin_n_i),
      .sync_o  (adapter_level)
   );
   level_sync #(.WIDTH(1)) u_button_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i (~push_button_pin_n_i),
      .sync_o  (button_level)
   );

   // ==========================================================
   // Bus line events
   assign rise  = scl_i & ~scl_q;
   assign fall  = ~scl_i & scl_q;
   assign start = scl_i & scl_q & sda_q & ~sda_i;
   assign stop  = scl_i & scl_q & ~sda_q & sda_i;

   // ==========================================================
   // Read mux; unmapped subaddresses read zero
   always_comb begin
      case (ptr_q)
         PMIC_STATUS_ADDR: rd_data = {seal_q, nvm_q, adapter_level, button_level,
                                      power_state_i, coin_q};
         POWER_CTRL_ADDR:  rd_data = {6'h00, pf_shdn_q, acq_q};
         RESUME_FLAG_ADDR: rd_data = flags_q;
         default:          rd_data = READ_ZERO;
      endcase
   end

   // ==========================================================
   // Serial slave
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      drv_d   = drv_q;
      oe_d    = oe_q;
      mack_d  = mack_q;
      load_tx = 1'b0;
      wr_en   = 1'b0;
      if (start) begin
         state_d = ST_ADDR;
         cnt_d   = 3'h0;
         drv_d   = 1'b0;
         oe_d    = 1'b0;
      end else if (stop) begin
         state_d = ST_IDLE;
         drv_d   = 1'b0;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_SUB, ST_WDATA: begin
               if (rise) begin
                  shift_d = {shift_q[6:0], sda_i};
                  cnt_d   = cnt_q + 3'h1;
                  if (cnt_q == 3'h7) begin
                     if (state_q == ST_ADDR) begin
                        rw_d    = shift_d[0];
                        // Other addresses get no acknowledge
                        state_d = (shift_d[7:1] == DEVICE_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                     end else if (state_q == ST_SUB) begin
                        ptr_d   = shift_d;
                        state_d = ST_SUB_ACK;
                     end else begin
                        wr_en   = 1'b1;
                        ptr_d   = ptr_q + 8'h01;
                        state_d = ST_WDATA_ACK;
                     end
                  end
               end
            end
            ST_ADDR_ACK, ST_SUB_ACK, ST_WDATA_ACK: begin
               if (fall) begin
                  if (!drv_q) begin
                     drv_d = 1'b1;
                     oe_d  = 1'b1;
                  end else begin
                     drv_d = 1'b0;
                     oe_d  = 1'b0;
                     cnt_d = 3'h0;
                     if (state_q == ST_ADDR_ACK && rw_q) begin
                        load_tx = 1'b1;
                     end else if (state_q == ST_ADDR_ACK) begin
                        state_d = ST_SUB;
                     end else begin
                        state_d = ST_WDATA;
                     end
                  end
               end
            end
            ST_RDATA: begin
               if (fall) begin
                  if (cnt_q == 3'h7) begin
                     oe_d    = 1'b0;
                     state_d = ST_MACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d    = ~shift_q[6];
                     cnt_d   = cnt_q + 3'h1;
                  end
               end
            end
            ST_MACK: begin
               if (rise) begin
                  mack_d = ~sda_i;
               end
               if (fall) begin
                  cnt_d = 3'h0;
                  if (mack_q) begin
                     load_tx = 1'b1;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
      // Pointer auto-increments so block reads walk the map
      if (load_tx) begin
         shift_d = rd_data;
         oe_d    = ~rd_data[7];
         ptr_d   = ptr_q + 8'h01;
         state_d = ST_RDATA;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q   <= 3'h0;
         shift_q <= 8'h00;
         ptr_q   <= 8'h00;
         rw_q    <= 1'b0;
         drv_q   <= 1'b0;
         oe_q    <= 1'b0;
         mack_q  <= 1'b0;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         ptr_q   <= ptr_d;
         rw_q    <= rw_d;
         drv_q   <= drv_d;
         oe_q    <= oe_d;
         mack_q  <= mack_d;
         scl_q   <= scl_i;
         sda_q   <= sda_i;
      end
   end

   // ==========================================================
   // Register group
   always_comb begin
      seal_d      = factory_seal_broken_i;
      nvm_d       = nvm_changed_i;
      pf_shdn_d   = pf_shdn_q;
      acq_d       = acq_q & ~coin_cell_done_i;
      acq_pulse_d = 1'b0;
      coin_d      = coin_cell_done_i ? coin_cell_result_i : coin_q;
      flags_d     = flags_q;
      // Status and flag writes fall through untouched
      if (wr_en && ptr_q == POWER_CTRL_ADDR) begin
         pf_shdn_d = shift_d[PF_SHDN_BIT];
         if (shift_d[COIN_ACQ_BIT]) begin
            acq_d       = 1'b1;
            acq_pulse_d = ~acq_q;
         end
      end
      if (power_up_i) begin
         flags_d = from_suspend_i ? suspend_enables_i : RESUME_FLAG_RST;
      end
      // Level request, held while the fail condition lasts
      shdn_d = pf_shdn_q & ~power_fail_out_n_i;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         seal_q      <= 1'b0;
         nvm_q       <= 1'b0;
         pf_shdn_q   <= POWER_CTRL_RST[PF_SHDN_BIT];
         acq_q       <= POWER_CTRL_RST[COIN_ACQ_BIT];
         acq_pulse_q <= 1'b0;
         shdn_q      <= 1'b0;
         coin_q      <= COIN_LEVEL_RST;
         flags_q     <= RESUME_FLAG_RST;
      end else begin
         seal_q      <= seal_d;
         nvm_q       <= nvm_d;
         pf_shdn_q   <= pf_shdn_d;
         acq_q       <= acq_d;
         acq_pulse_q <= acq_pulse_d;
         shdn_q      <= shdn_d;
         coin_q      <= coin_d;
         flags_q     <= flags_d;
      end
   end

   // ==========================================================
   // Outputs
   assign sda_o               = 1'b0;
   assign sda_oe_o            = oe_q;
   assign shutdown_all_o      = shdn_q;
   assign coin_cell_acquire_o = acq_pulse_q;
endmodule // pmic_status_control_flags
`default_nettype wire

// *** sim/pmic_flags_props.sv ***
// Concurrent checks on the status, control and flag register block
`timescale 1ns/1ps
`default_nettype none
module pmic_flags_props (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_i,
   // Observed ports
   input  wire logic scl_i,
   input  wire logic power_fail_out_n_i,
   input  wire logic sda_oe_o,
   input  wire logic shutdown_all_o,
   input  wire logic coin_cell_acquire_o
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   a_pf_cause_low: assert property (shutdown_all_o |-> !$past(power_fail_out_n_i))
      else $error("shutdown without power fail low");
   a_pf_high_idle: assert property (power_fail_out_n_i |=> !shutdown_all_o)
      else $error("shutdown while power fail high");
   a_acq_one_cycle: assert property (coin_cell_acquire_o |=> !coin_cell_acquire_o)
      else $error("acquire pulse longer than one cycle");
   a_acq_from_write: assert property (coin_cell_acquire_o |-> $past(scl_i))
      else $error("acquire not launched by a bus data bit");
   a_acq_on_rise: assert property (coin_cell_acquire_o |-> $past(scl_i) && !$past(scl_i, 2))
      else $error("acquire not one clock after a bus clock rise");
   a_reset_quiet: assert property ($fell(rst_i) |-> !shutdown_all_o && !coin_cell_acquire_o
                                   && !sda_oe_o)
      else $error("outputs active right after reset");
endmodule // pmic_flags_props
bind pmic_status_control_flags pmic_flags_props pmic_flags_props_i (
   .clock_i            (clock_i),
   .rst_i              (rst_i),
   .scl_i              (scl_i),
   .power_fail_out_n_i (power_fail_out_n_i),
   .sda_oe_o           (sda_oe_o),
   .shutdown_all_o     (shutdown_all_o),
   .coin_cell_acquire_o(coin_cell_acquire_o)
);
`default_nettype wire

// *** sim/bus_host.sv ***
// Serial register bus host model
`timescale 1ns/1ps
`default_nettype none
module bus_host (
   // Clock and bus
   input  wire logic clock_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // ==========================================================
   // Bit phases of four system clocks; sda moves only while scl is low, except for the start and stop edges
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic qtr();
      repeat (4) @(negedge clock_i);
   endtask
   task automatic start();
      sda_o = 1'b1;
      qtr();
      scl_o = 1'b1;
      qtr();
      sda_o = 1'b0;
      qtr();
      scl_o = 1'b0;
      qtr();
   endtask
   task automatic stop();
      sda_o = 1'b0;
      qtr();
      scl_o = 1'b1;
      qtr();
      sda_o = 1'b1;
      qtr();
   endtask
   task automatic xfer(input logic b, output logic r);
      sda_o = b;
      qtr();
      scl_o = 1'b1;
      qtr();
      r = sda_i;
      qtr();
      scl_o = 1'b0;
      qtr();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, nack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
      xfer(last, r);
   endtask
endmodule // bus_host
`default_nettype wire

// *** sim/pmic_status_control_flags_bench.sv ***
// Self-checking bench for the status, control and flag registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pmic_status_control_flags_bench import pmic_flags_pkg::*;;
   logic clock_i, rst_i, scl, sda_host, sda_o, sda_oe_o, seal, nvm, ad_n, pb_n, pf_n;
   logic pup, from_susp, shutdown, done, acquire, nk;
   logic [1:0] pstate, result, coin_exp;
   logic [7:0] susp_en, d;
   int         n_fail, tests_run, n_acq;
   // Open drain: the block can only pull low, the host side is the pull-up
   wire        sda_line = sda_host & (~sda_oe_o | sda_o);

   bus_host bus_host_i (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_o(sda_host));
   pmic_status_control_flags pmic_status_control_flags_i (
      .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .factory_seal_broken_i(seal), .nvm_changed_i(nvm),
      .adapter_detect_pin_n_i(ad_n), .push_button_pin_n_i(pb_n), .power_fail_out_n_i(pf_n),
      .power_state_i(pstate), .power_up_i(pup), .from_suspend_i(from_susp),
      .suspend_enables_i(susp_en), .shutdown_all_o(shutdown), .coin_cell_done_i(done),
      .coin_cell_result_i(result), .coin_cell_acquire_o(acquire));

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   always @(posedge clock_i) if (acquire === 1'b1) n_acq++;

   // ==========================================================
   // Bus access and closing
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      bus_host_i.start();
      bus_host_i.wbyte({DEVICE_ADDR, 1'b0}, nk);
      bus_host_i.wbyte(a, nk);
      bus_host_i.wbyte(v, nk);
      bus_host_i.stop();
   endtask
   task automatic reg_rd(input logic [7:0] a);
      bus_host_i.start();
      bus_host_i.wbyte({DEVICE_ADDR, 1'b0}, nk);
      bus_host_i.wbyte(a, nk);
      bus_host_i.start();
      bus_host_i.wbyte({DEVICE_ADDR, 1'b1}, nk);
      bus_host_i.rbyte(1'b1, d);
      bus_host_i.stop();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clock_i) s = 1'b1;
      @(negedge clock_i) s = 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      reg_rd(POWER_CTRL_ADDR);
      `CHK("control rst", 8'h00, d)
      reg_rd(RESUME_FLAG_ADDR);
      `CHK("flags rst", 8'h00, d)
      reg_rd(PMIC_STATUS_ADDR);
      `CHK("status top", 2'h0, d[7:6])
   endtask
   task automatic t_status();
      for (int s = 0; s < 4; s++) begin
         {nvm, seal} = 2'(s);
         ad_n = s[0];
         pb_n = ~s[1];
         pstate = 2'(s);
         reg_wr(PMIC_STATUS_ADDR, 8'(s * 8'h55));
         reg_rd(PMIC_STATUS_ADDR);
         `CHK("status", {seal, nvm, ~ad_n, ~pb_n, pstate, coin_exp}, d)
      end
   endtask
   task automatic t_control();
      for (int r = 1; r >= 0; r--) begin
         n_acq = 0;
         reg_wr(POWER_CTRL_ADDR, 8'hFD);
         reg_rd(POWER_CTRL_ADDR);
         `CHK("acq busy", 8'h01, d)
         `CHK("acq pulses", 1, n_acq)
         result = 2'(r);
         pulse(done);
         coin_exp = 2'(r);
         reg_rd(POWER_CTRL_ADDR);
         `CHK("acq clear", 8'h00, d)
         reg_rd(PMIC_STATUS_ADDR);
         `CHK("coin", coin_exp, d[1:0])
      end
      reg_wr(POWER_CTRL_ADDR, 8'h00);
      `CHK("acq zero", 1, n_acq)
   endtask
   task automatic t_foreign();
      reg_wr(POWER_CTRL_ADDR, 8'h02);
      bus_host_i.start();
      bus_host_i.wbyte({DEVICE_ADDR ^ 7'h01, 1'b0}, nk);
      bus_host_i.wbyte(POWER_CTRL_ADDR, nk);
      bus_host_i.wbyte(8'h00, nk);
      bus_host_i.stop();
      reg_rd(POWER_CTRL_ADDR);
      `CHK("foreign wr", 8'h02, d)
   endtask
   task automatic t_pfail();
      for (int b = 1; b >= 0; b--) begin
         reg_wr(POWER_CTRL_ADDR, 8'(b * 2));
         reg_rd(POWER_CTRL_ADDR);
         `CHK("pf bit", 8'(b * 2), d)
         pf_n = 1'b0;
         repeat (2) @(negedge clock_i);
         `CHK("shutdown", 1'(b), shutdown)
         pf_n = 1'b1;
      end
   endtask
   task automatic t_flags();
      from_susp = 1'b1;
      susp_en = 8'hA5;
      pulse(pup);
      reg_wr(RESUME_FLAG_ADDR, 8'hFF);
      reg_rd(RESUME_FLAG_ADDR);
      `CHK("flags susp", 8'hA5, d)
      susp_en = 8'h5A;
      pulse(pup);
      reg_rd(RESUME_FLAG_ADDR);
      `CHK("flags susp2", 8'h5A, d)
      from_susp = 1'b0;
      pulse(pup);
      reg_rd(RESUME_FLAG_ADDR);
      `CHK("flags off", 8'h00, d)
   endtask

   initial begin
      rst_i = 1'b1;
      {seal, nvm, pup, from_susp, done} = '0;
      {ad_n, pb_n, pf_n} = 3'h7;
      pstate = 2'h0;
      result = 2'h0;
      coin_exp = COIN_LEVEL_RST;
      susp_en = 8'h00;
      repeat (2) @(negedge clock_i);
      rst_i = 1'b0;
      t_reset();
      t_status();
      t_control();
      t_foreign();
      t_pfail();
      t_flags();
      end_of_test();
   end
   initial begin
      // A little over twice the length of all scenarios together
      repeat (40000) @(posedge clock_i);
      n_fail++;
      end_of_test();
   end
endmodule // pmic_status_control_flags_bench
`default_nettype wire
